// ---- hdl/pwm_fault_consts.vh ----
// Register map, field positions and reset values of the PWM fault override block
`ifndef PWM_FAULT_CONSTS_VH
`define PWM_FAULT_CONSTS_VH

`define ADDR_FAULT_LIMIT_CTRL   5'h00
`define ADDR_FAULT_OVERRIDE     5'h04
`define ADDR_FAULT_STATUS       5'h08
`define ADDR_FAULT_CLEAR        5'h0C
`define ADDR_PWM_CONTROL        5'h10

`define SRC_MSB                 7
`define SRC_LSB                 3
`define POL_BIT                 2
`define MODE_MSB                1
`define MODE_LSB                0

`define SRC_LAST                5'h04
`define MODE_LATCHED            2'h0
`define MODE_CYCLE              2'h1
`define MODE_RESERVED           2'h2
`define MODE_DISABLED           2'h3

`define FAULT_CTRL_RESET        16'h0003
`define OVERRIDE_RESET          2'h0
`define PWM_CONTROL_RESET       2'h0

`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// ---- hdl/pwm_fault_override_control.v ----
// PWM generator fault selection, polarity and override logic with AXI4-Lite registers
//
// Operation
// RULE1 - Five-bit source field picks fault input 1..5; higher codes reserved, never fault.
// RULE2 - Polarity bit 1 means active-low fault input, 0 means active-high.
// RULE3 - Mode 11 ignores the fault input; no override applied.
// RULE4 - Mode 01 overrides both outputs while the fault is asserted, cycle by cycle.
// RULE5 - Mode 00 overrides both outputs and latches the forced state once seen.
// RULE6 - Software must not write mode 10; it is reserved.
// RULE7 - Software should change fault fields only while master enable is 0.
// RULE8 - Independent mode with fault 1 as fault: point current-limit source elsewhere.
// RULE9 - Independent mode with fault 1 as current limit: point fault source elsewhere.
// RULE10 - Fault inputs are synchronised to the clock before polarity and mode logic.
// RULE11 - Latched override holds until the fault is gone and software or reset clears it.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_fault_consts.vh"

module pwm_fault_override_control (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [4:0]  faultInputs,
    input  wire        pwmHighIn,
    input  wire        pwmLowIn,
    output reg         highSideOutput,
    output reg         lowSideOutput,
    output wire        pwmMasterEnable,
    output wire        independentFaultEnable,
    output wire [4:0]  currentLimitSourceSelect,
    output wire        faultActive,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready
);

    // Control and status registers
    reg  [15:0] faultCtrl_reg;
    reg  [1:0]  faultOverrideValues_reg;
    reg  [1:0]  pwmControl_reg;
    // Metastability stage; read by nothing but the second flop
    reg  [4:0]  faultMeta_reg;
    reg  [4:0]  faultSync_reg;
    reg         latched_reg;

    // Bus slave state
    reg  [4:0]  awAddr_reg;
    reg         awHeld_reg;
    reg  [31:0] wData_reg;
    reg  [3:0]  wStrb_reg;
    reg         wHeld_reg;
    reg         bValid_reg;
    reg  [1:0]  bResp_reg;
    reg         rValid_reg;
    reg  [31:0] rData_reg;
    reg  [1:0]  rResp_reg;

    wire [4:0]  faultSourceSelect = faultCtrl_reg[`SRC_MSB:`SRC_LSB];
    wire        faultInputPolarity = faultCtrl_reg[`POL_BIT];
    wire [1:0]  faultResponseMode = faultCtrl_reg[`MODE_MSB:`MODE_LSB];

    // Merge byte lanes into an old word
    function [31:0] mergeBytes;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0]  strb;
        integer i;
        begin
            mergeBytes = oldWord;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
                end
            end
        end
    endfunction

    function isMapped;
        input [4:0] addr;
        begin
            case (addr)
                `ADDR_FAULT_LIMIT_CTRL: isMapped = 1'b1;
                `ADDR_FAULT_OVERRIDE:   isMapped = 1'b1;
                `ADDR_FAULT_STATUS:     isMapped = 1'b1;
                `ADDR_FAULT_CLEAR:      isMapped = 1'b1;
                `ADDR_PWM_CONTROL:      isMapped = 1'b1;
                default:                isMapped = 1'b0;
            endcase
        end
    endfunction

    // Low address bits dropped: registers are whole words
    function [4:0] wordAddr;
        input [4:0] addr;
        begin
            wordAddr = {addr[4:2], 2'h0};
        end
    endfunction

    // Fault source selection and polarity
    reg selectedRaw;
    always @* begin
        if (faultSourceSelect <= `SRC_LAST) begin
            selectedRaw = faultSync_reg[faultSourceSelect[2:0]]; // see RULE1
        end else begin
            selectedRaw = 1'b0; // see RULE1
        end
    end

    // Reserved codes select nothing, so polarity is applied only to a real input
    wire sourceValid = (faultSourceSelect <= `SRC_LAST);
    wire faultAsserted = sourceValid & (selectedRaw ^ faultInputPolarity); // see RULE2

    // Mode 10 treated like disabled: no defined behaviour, so safest is no override
    wire cycleForce = (faultResponseMode == `MODE_CYCLE) & faultAsserted; // see RULE4
    wire latchForce = (faultResponseMode == `MODE_LATCHED) & (faultAsserted | latched_reg);
    wire forceOverride = cycleForce | latchForce; // see RULE3
    assign faultActive = forceOverride;

    // AXI handshake
    // Response must clear before the next write lands, so one write at a time
    wire doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
    assign s_axi_awready = ~awHeld_reg;
    assign s_axi_wready  = ~wHeld_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = ~rValid_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;

    wire clearWrite = doWrite & (awAddr_reg == `ADDR_FAULT_CLEAR) & wStrb_reg[0] & wData_reg[0];

    // Lanes merged on a full word; only the low half is stored
    wire [31:0] ctrlMerged = mergeBytes({16'h0000, faultCtrl_reg}, wData_reg, wStrb_reg);
    // Read address aligned once, used by decode and response
    wire [4:0]  readAddr   = wordAddr(s_axi_araddr);

    assign pwmMasterEnable          = pwmControl_reg[0];
    assign independentFaultEnable   = pwmControl_reg[1];
    assign currentLimitSourceSelect = faultCtrl_reg[15:11];

    // Two flops: raw sensor edges must not reach the mode logic
    always @(posedge core_clk) begin
        if (rst) begin
            faultMeta_reg <= 5'h00;
            faultSync_reg <= 5'h00;
        end else begin
            faultMeta_reg <= faultInputs; // see RULE10
            faultSync_reg <= faultMeta_reg; // see RULE10
        end
    end

    // Latch: new fault wins over a clear in the same cycle
    // Leaving latched mode drops any held fault
    always @(posedge core_clk) begin
        if (rst) begin
            latched_reg <= 1'b0; // see RULE11
        end else if (faultResponseMode != `MODE_LATCHED) begin
            latched_reg <= 1'b0;
        end else if (faultAsserted) begin
            latched_reg <= 1'b1; // see RULE5
        end else if (clearWrite) begin
            latched_reg <= 1'b0; // see RULE11
        end
    end

    // Forced value replaces the drive one edge after the flag rises
    always @(posedge core_clk) begin
        if (rst) begin
            highSideOutput <= 1'b0;
        end else if (forceOverride) begin
            highSideOutput <= faultOverrideValues_reg[1]; // see RULE4
        end else begin
            highSideOutput <= pwmHighIn;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            lowSideOutput <= 1'b0;
        end else if (forceOverride) begin
            lowSideOutput <= faultOverrideValues_reg[0]; // see RULE5
        end else begin
            lowSideOutput <= pwmLowIn;
        end
    end

    // Write channel
    always @(posedge core_clk) begin
        if (rst) begin
            awAddr_reg <= 5'h00;
            awHeld_reg <= 1'b0;
            wData_reg  <= 32'h0000_0000;
            wStrb_reg  <= 4'h0;
            wHeld_reg  <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg  <= `RESP_OKAY;
            faultCtrl_reg           <= `FAULT_CTRL_RESET;
            faultOverrideValues_reg <= `OVERRIDE_RESET;
            pwmControl_reg          <= `PWM_CONTROL_RESET;
        end else begin
            if (s_axi_awvalid && !awHeld_reg) begin
                awAddr_reg <= wordAddr(s_axi_awaddr);
                awHeld_reg <= 1'b1;
            end
            if (s_axi_wvalid && !wHeld_reg) begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
                wHeld_reg <= 1'b1;
            end
            if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg  <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg  <= isMapped(awAddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
                case (awAddr_reg)
                    `ADDR_FAULT_LIMIT_CTRL: begin
                        // Mode 10 is stored as written; logic gives it no override
                        faultCtrl_reg <= ctrlMerged[15:0]; // see RULE6
                    end
                    `ADDR_FAULT_STATUS: begin
                        // Read-only view; write answered but dropped
                    end
                    `ADDR_FAULT_CLEAR: begin
                        // Acts through clearWrite; nothing stored
                    end
                    `ADDR_FAULT_OVERRIDE: begin
                        if (wStrb_reg[0]) begin
                            faultOverrideValues_reg <= wData_reg[1:0];
                        end
                    end
                    `ADDR_PWM_CONTROL: begin
                        if (wStrb_reg[0]) begin
                            pwmControl_reg <= wData_reg[1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read channel
    // One read at a time: arready stays low while an answer stands
    always @(posedge core_clk) begin
        if (rst) begin
            rValid_reg <= 1'b0;
            rData_reg  <= 32'h0000_0000;
            rResp_reg  <= `RESP_OKAY;
        end else if (rValid_reg) begin
            if (s_axi_rready) begin
                rValid_reg <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            rValid_reg <= 1'b1;
            rResp_reg  <= isMapped(readAddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (readAddr)
                `ADDR_FAULT_LIMIT_CTRL: begin
                    rData_reg <= {16'h0000, faultCtrl_reg};
                end
                `ADDR_FAULT_OVERRIDE: begin
                    rData_reg <= {30'h0000_0000, faultOverrideValues_reg};
                end
                `ADDR_FAULT_STATUS: begin
                    // Synced levels, so software sees what the logic acts on
                    rData_reg <= {24'h00_0000, faultSync_reg,
                                  faultAsserted, latched_reg, forceOverride};
                end
                `ADDR_PWM_CONTROL: begin
                    rData_reg <= {30'h0000_0000, pwmControl_reg};
                end
                default: begin
                    rData_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- tb/pwm_fault_override_control_assertions.sv ----
// Port-level property checks for the PWM fault override block
`timescale 1ns/10ps
`default_nettype none
module pwm_fault_override_control_assertions (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [4:0] faultInputs,
    input wire logic       pwmHighIn,
    input wire logic       pwmLowIn,
    input wire logic       highSideOutput,
    input wire logic       lowSideOutput,
    input wire logic       faultActive,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_bvalid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_reset_idle;
        $fell(rst) |-> !highSideOutput && !lowSideOutput && !faultActive && !s_axi_bvalid
            && !s_axi_rvalid && s_axi_awready && s_axi_wready && s_axi_arready;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong");
    property p_pass;
        !faultActive |=> highSideOutput == $past(pwmHighIn) && lowSideOutput == $past(pwmLowIn);
    endproperty
    a_pass: assert property (p_pass) else $error("outputs not following drive");
    // Forced pins may only move when an override write lands
    property p_force_hold;
        faultActive && $past(faultActive) && !s_axi_bvalid |=>
            $stable(highSideOutput) && $stable(lowSideOutput);
    endproperty
    a_force_hold: assert property (p_force_hold) else $error("forced pins moved");
    // Two sync stages: a fresh input edge cannot reach the flag yet
    property p_sync;
        !$stable(faultInputs) && $past(faultInputs, 2) == $past(faultInputs, 3)
            && !s_axi_bvalid |-> $stable(faultActive);
    endproperty
    a_sync: assert property (p_sync) else $error("fault flag not synchronised");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_read_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read answer dropped");
    property p_write_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write answer dropped");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule
`default_nettype wire

// ---- tb/fault_stage_model.sv ----
// Fault sensors and gate-drive source in front of the PWM fault override block
`timescale 1ns/10ps
`default_nettype none
module fault_stage_model (
    input  wire logic       core_clk,
    input  wire logic [4:0] faultCmd,
    input  wire logic       activeLow,
    output wire logic [4:0] faultInputs,
    output wire logic       pwmHighIn,
    output wire logic       pwmLowIn
);
    logic [1:0] phase = 2'h0;
    // Sensor level follows the wired polarity
    assign faultInputs = faultCmd ^ {5{activeLow}};
    // Two bits of one counter drive the pins, toggling every cycle and every second cycle, so pass-through is visible
    always @(posedge core_clk) begin
        phase <= phase + 2'h1;
    end
    assign pwmHighIn = phase[0];
    assign pwmLowIn  = phase[1];
endmodule
`default_nettype wire

// ---- tb/pwm_fault_override_control_tb_top.sv ----
// Self-checking bench for the PWM fault override block
`timescale 1ns/10ps
`default_nettype none
`include "pwm_fault_consts.vh"
module pwm_fault_override_control_tb_top;
    logic        core_clk = 1'h0, rst = 1'h1, activeLow = 1'h0, s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0, faultCmd = 5'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    wire         highSideOutput, lowSideOutput, pwmMasterEnable, independentFaultEnable;
    wire         faultActive, pwmHighIn, pwmLowIn, s_axi_awready, s_axi_wready;
    wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [4:0]  currentLimitSourceSelect, faultInputs;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          errors = 0, nTests = 0;
    pwm_fault_override_control u_pwm_fault_override_control (
        .core_clk(core_clk), .rst(rst), .faultInputs(faultInputs), .pwmHighIn(pwmHighIn),
        .pwmLowIn(pwmLowIn), .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput),
        .pwmMasterEnable(pwmMasterEnable), .independentFaultEnable(independentFaultEnable),
        .currentLimitSourceSelect(currentLimitSourceSelect), .faultActive(faultActive),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    fault_stage_model u_fault_stage_model (.core_clk, .faultCmd, .activeLow, .faultInputs,
        .pwmHighIn, .pwmLowIn);
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nTests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wrReg(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, r);
    endtask
    task automatic rdReg(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
    endtask
    // Pins are only compared while forced; otherwise they carry the drive
    task automatic fSet(input logic [4:0] c, input logic [2:0] e);
        @(posedge core_clk);
        faultCmd <= c;
        repeat (4) @(posedge core_clk);
        chk({faultActive, e[2] ? {highSideOutput, lowSideOutput} : 2'h0}, e);
    endtask
    task automatic tRegs;
        rdReg(`ADDR_FAULT_LIMIT_CTRL, `FAULT_CTRL_RESET, `RESP_OKAY);
        rdReg(`ADDR_FAULT_OVERRIDE, 32'h0, `RESP_OKAY);
        rdReg(`ADDR_PWM_CONTROL, 32'h0, `RESP_OKAY);
        rdReg(5'h14, 32'h0, `RESP_SLVERR);
        wrReg(5'h14, 32'hFFFF, `RESP_SLVERR);
        rdReg(`ADDR_FAULT_LIMIT_CTRL, `FAULT_CTRL_RESET, `RESP_OKAY);
        $display("tRegs done");
    endtask
    task automatic tSel;
        logic [4:0] s;
        for (int i = 0; i < 10; i++) begin
            s = 5'(i / 2);
            wrReg(`ADDR_PWM_CONTROL, 32'h0, `RESP_OKAY);
            wrReg(`ADDR_FAULT_OVERRIDE, 32'h2, `RESP_OKAY);
            wrReg(`ADDR_FAULT_LIMIT_CTRL, {16'h0, 5'h1F, 3'h0, s, i[0], `MODE_CYCLE},
                `RESP_OKAY);
            wrReg(`ADDR_PWM_CONTROL, 32'h3, `RESP_OKAY);
            activeLow <= i[0];
            fSet(~(5'h1 << s), 3'h0);
            fSet(5'h1 << s, 3'h6);
            fSet(5'h0, 3'h0);
        end
        chk({currentLimitSourceSelect, independentFaultEnable, pwmMasterEnable}, 32'h7F);
        wrReg(`ADDR_PWM_CONTROL, 32'h0, `RESP_OKAY);
        activeLow <= 1'h0;
        $display("tSel done");
    endtask
    task automatic tQuiet;
        // Mode 10 is never written: reserved
        for (int m = 1; m < 4; m += 2) begin
            wrReg(`ADDR_FAULT_LIMIT_CTRL, {24'h0, m == 1 ? 5'h5 : 5'h0, 1'h0, 2'(m)},
                `RESP_OKAY);
            fSet(5'h1F, 3'h0);
        end
        $display("tQuiet done");
    endtask
    task automatic tLatch;
        wrReg(`ADDR_FAULT_LIMIT_CTRL, {24'h0, 5'h2, 1'h0, `MODE_LATCHED}, `RESP_OKAY);
        fSet(5'h4, 3'h6);
        wrReg(`ADDR_FAULT_CLEAR, 32'h1, `RESP_OKAY);
        fSet(5'h0, 3'h6);
        wrReg(`ADDR_FAULT_CLEAR, 32'h1, `RESP_OKAY);
        fSet(5'h0, 3'h0);
        rdReg(`ADDR_FAULT_CLEAR, 32'h0, `RESP_OKAY);
        $display("tLatch done");
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'h0;
        tRegs;
        tSel;
        tQuiet;
        tLatch;
        tally_and_finish;
    end
    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        tally_and_finish;
    end
endmodule
bind pwm_fault_override_control pwm_fault_override_control_assertions
    u_pwm_fault_override_control_assertions (
        .core_clk(core_clk), .rst(rst), .faultInputs(faultInputs), .pwmHighIn(pwmHighIn),
        .pwmLowIn(pwmLowIn), .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput),
        .faultActive(faultActive), .s_axi_awready(s_axi_awready),
        .s_axi_wready(s_axi_wready), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rready(s_axi_rready),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bvalid(s_axi_bvalid));
`default_nettype wire
